// >>> inc/prc_defines.vh
// Purpose: constants of the pump remote contact block
// Assumes: 125 MHz aclk
// Notes: times in their own unit, cycle counts derived from them
`ifndef PRC_DEFINES_VH
`define PRC_DEFINES_VH

`define PRC_CLK_HZ 125000000
// register byte offsets
`define PRC_OFS_CTRL 8'h00
`define PRC_OFS_STATUS 8'h04
`define PRC_OFS_IRQ_STAT 8'h08
`define PRC_OFS_IRQ_MASK 8'h0C
`define PRC_OFS_RATED 8'h10
`define PRC_OFS_TXDATA 8'h14
// control fields
`define PRC_CTRL_SEMI 0
`define PRC_CTRL_RST 32'h0000_0000
`define PRC_RATED_RST 16'h0000
// status fields
`define PRC_ST_RUN 0
`define PRC_ST_LOWSPD 1
`define PRC_ST_REMOTE 2
`define PRC_ST_ALARM 3
`define PRC_ST_WARN 4
`define PRC_ST_VALID 5
`define PRC_ST_TXBUSY 6
// interrupt fields
`define PRC_IRQ_ALARM 0
`define PRC_IRQ_WARN 1
`define PRC_IRQ_RESET 2
`define PRC_IRQ_VALID 3
`define PRC_IRQ_MODE 4
`define PRC_IRQ_W 5
// timing
`define PRC_VALID_S 6
`define PRC_VALID_CYC (`PRC_VALID_S * `PRC_CLK_HZ)
`define PRC_DEB_MS 10
`define PRC_DEB_CYC (`PRC_DEB_MS * (`PRC_CLK_HZ / 1000))
`define PRC_HOLD_MS 2000
`define PRC_HOLD_CYC (`PRC_HOLD_MS * (`PRC_CLK_HZ / 1000))
// serial character format
`define PRC_BAUD 9600
`define PRC_BAUD_CYC (`PRC_CLK_HZ / `PRC_BAUD)
`define PRC_DATA_BITS 8
`define PRC_FRAME_BITS 10
// speed threshold as ratio num/den of rated speed
`define PRC_SPD_NUM 4
`define PRC_SPD_DEN 5
// axi responses
`define PRC_RESP_OKAY 2'b00
`define PRC_RESP_SLVERR 2'b10

`endif

// >>> logic/prc_debounce.v
// Purpose: synchronise and debounce one contact input
// Assumes: raw input is asynchronous to aclk
// Notes: output moves only after the level is stable for STABLE cycles
`timescale 1ns/1ps
`default_nettype none
module prc_debounce #(
    parameter integer STABLE = 1250000
) (
    // clock
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // contact
    input wire raw,
    output reg level_q
);

reg s1_q;
reg s2_q;
reg s3_q;
reg [31:0] cnt_q;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        s3_q <= 1'b1;
        cnt_q <= 32'h0000_0000;
        level_q <= 1'b1;
    end
    else if (ce)
    begin
        s1_q <= raw;
        s2_q <= s1_q;
        s3_q <= s2_q;
        // bounce restarts the count, so one closure gives one change
        if (s2_q == s3_q && s3_q != level_q)
        begin
            if (cnt_q >= STABLE - 1)
            begin
                level_q <= s3_q;
                cnt_q <= 32'h0000_0000;
            end
            else
                cnt_q <= cnt_q + 32'h0000_0001;
        end
        else
            cnt_q <= 32'h0000_0000;
    end
end

endmodule
`default_nettype wire

// >>> logic/prc_io.v
// Purpose: remote contact inputs, status contact outputs, serial framer
// Assumes: contacts read 0 when closed to ground; axi4-lite host
// Notes: contact outputs are 1 for a closed contact
//
// What this block does
// - start contact closure starts the pump
// - stop contact opened stops the pump
// - alternate switch on stop runs while closed
// - stop wins over start
// - one reset event per reset closure
// - low speed contact closed gives reduced speed
// - rotation contact closed while rotor turns
// - at-speed contact closed above eighty percent
// - accelerating contact closed while accelerating
// - decelerating contact closed while decelerating
// - remote contact closed while remote permitted
// - alarm make closes, break opens together
// - warning make closes, break opens together
// - status invalid for six seconds after power-up
// - serial setting selects signal convention
// - 9600 baud, 8 data, no parity, 1 stop
// - held panel reset toggles remote/local mode
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.vh"
module prc_io #(
    parameter integer VALID_CYC = `PRC_VALID_CYC,
    parameter integer DEB_CYC = `PRC_DEB_CYC,
    parameter integer HOLD_CYC = `PRC_HOLD_CYC,
    parameter integer BAUD_CYC = `PRC_BAUD_CYC
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    input wire ce,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // remote contact pins, low when closed
    input wire start_in_n,
    input wire stop_in_n,
    input wire reset_in_n,
    input wire lowspd_in_n,
    input wire panel_reset_n,
    // pump state from the drive logic
    input wire rotor_turning,
    input wire [15:0] speed,
    input wire accelerating,
    input wire decelerating,
    input wire alarm_cause,
    input wire warn_cause,
    input wire local_run,
    // commands to the drive logic
    output reg run_q,
    output reg low_speed_q,
    output reg alarm_reset_q,
    // status contacts, 1 = closed
    output reg rot_make_q,
    output reg atspd_make_q,
    output reg accel_make_q,
    output reg decel_make_q,
    output reg remote_make_q,
    output reg alarm_make_q,
    output reg alarm_break_q,
    output reg warn_make_q,
    output reg warn_break_q,
    output reg status_valid_q,
    // serial and interrupt
    output reg ser_tx_q,
    output reg irq_q
);

////////////////////////////////////////////////////////////////////////////////
// contact inputs

localparam integer NIN = 5;
wire [NIN-1:0] raw_in;
wire [NIN-1:0] deb;
assign raw_in = {panel_reset_n, lowspd_in_n, reset_in_n, stop_in_n, start_in_n};

genvar gi;
generate
    for (gi = 0; gi < NIN; gi = gi + 1)
    begin : g_deb
        prc_debounce #(
            .STABLE(DEB_CYC)
        ) u_deb (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .raw(raw_in[gi]),
            .level_q(deb[gi])
        );
    end
endgenerate

wire start_cl = ~deb[0];
wire stop_cl = ~deb[1];
wire reset_cl = ~deb[2];
wire lowspd_cl = ~deb[3];
wire panel_cl = ~deb[4];

////////////////////////////////////////////////////////////////////////////////
// registers

reg [31:0] ctrl_q;
reg [15:0] rated_q;
reg [`PRC_IRQ_W-1:0] irq_stat_q;
reg [`PRC_IRQ_W-1:0] irq_mask_q;
reg remote_q;
reg alarm_q;
reg reset_cl_q;
reg panel_cl_q;
reg hold_done_q;
reg [31:0] hold_cnt_q;
reg [31:0] valid_cnt_q;
reg warn_q;
reg [9:0] tx_sh_q;
reg [3:0] tx_bits_q;
reg [31:0] baud_cnt_q;

wire semi_mode = ctrl_q[`PRC_CTRL_SEMI];
wire tx_busy = (tx_bits_q != 4'h0);

////////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

reg aw_have_q;
reg w_have_q;
reg [7:0] aw_addr_q;
reg [31:0] w_data_q;
reg [3:0] w_strb_q;

wire aw_take = s_axi_awvalid & s_axi_awready;
wire w_take = s_axi_wvalid & s_axi_wready;
wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
wire wr_hit = (aw_addr_q == `PRC_OFS_CTRL) | (aw_addr_q == `PRC_OFS_IRQ_STAT) |
              (aw_addr_q == `PRC_OFS_IRQ_MASK) | (aw_addr_q == `PRC_OFS_RATED) |
              (aw_addr_q == `PRC_OFS_TXDATA);
wire wr_ctrl = wr_go & (aw_addr_q == `PRC_OFS_CTRL) & w_strb_q[0];
wire wr_clr = wr_go & (aw_addr_q == `PRC_OFS_IRQ_STAT) & w_strb_q[0];
wire wr_mask = wr_go & (aw_addr_q == `PRC_OFS_IRQ_MASK) & w_strb_q[0];
wire wr_rated = wr_go & (aw_addr_q == `PRC_OFS_RATED);
wire wr_tx = wr_go & (aw_addr_q == `PRC_OFS_TXDATA) & w_strb_q[0];

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        aw_addr_q <= 8'h00;
        w_data_q <= 32'h0000_0000;
        w_strb_q <= 4'h0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `PRC_RESP_OKAY;
    end
    else if (ce)
    begin
        if (aw_take)
        begin
            aw_have_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
        end
        if (w_take)
        begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (wr_go)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
        end
        else if (s_axi_bvalid & s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

reg [31:0] rd_word;
reg rd_hit;
always @*
begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
        `PRC_OFS_CTRL: rd_word = ctrl_q;
        `PRC_OFS_STATUS:
        begin
            rd_word[`PRC_ST_RUN] = run_q;
            rd_word[`PRC_ST_LOWSPD] = low_speed_q;
            rd_word[`PRC_ST_REMOTE] = remote_q;
            rd_word[`PRC_ST_ALARM] = alarm_q;
            rd_word[`PRC_ST_WARN] = warn_q;
            rd_word[`PRC_ST_VALID] = status_valid_q;
            rd_word[`PRC_ST_TXBUSY] = tx_busy;
        end
        `PRC_OFS_IRQ_STAT: rd_word[`PRC_IRQ_W-1:0] = irq_stat_q;
        `PRC_OFS_IRQ_MASK: rd_word[`PRC_IRQ_W-1:0] = irq_mask_q;
        `PRC_OFS_RATED: rd_word[15:0] = rated_q;
        `PRC_OFS_TXDATA: rd_word[7:0] = tx_sh_q[8:1];
        default: rd_hit = 1'b0;
    endcase
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `PRC_RESP_OKAY;
    end
    else if (ce)
    begin
        if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
        end
        else if (s_axi_rvalid & s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// mode, run, reset and alarm logic

wire reset_evt = reset_cl & ~reset_cl_q & remote_q;
wire panel_rel = ~panel_cl & panel_cl_q & ~hold_done_q;
wire hold_hit = panel_cl & ~hold_done_q & (hold_cnt_q >= HOLD_CYC - 1);
wire any_reset = reset_evt | panel_rel;
wire alarm_set = alarm_cause & ~alarm_q;
wire warn_rise = warn_cause & ~warn_q;
wire valid_rise = ~status_valid_q & (valid_cnt_q >= VALID_CYC - 1);

// standard: start closure latches run while stop stays closed, which also
// serves an alternate switch on stop with start strapped closed
// semi convention: both contacts must be held closed to keep running
reg run_d;
always @*
begin
    run_d = local_run;
    if (remote_q)
    begin
        if (semi_mode)
            run_d = stop_cl & start_cl;
        else
            run_d = stop_cl & (run_q | start_cl);
    end
end

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        ctrl_q <= `PRC_CTRL_RST;
        rated_q <= `PRC_RATED_RST;
        irq_mask_q <= {`PRC_IRQ_W{1'b0}};
        remote_q <= 1'b1;
        alarm_q <= 1'b0;
        warn_q <= 1'b0;
        reset_cl_q <= 1'b0;
        panel_cl_q <= 1'b0;
        hold_done_q <= 1'b0;
        hold_cnt_q <= 32'h0000_0000;
        valid_cnt_q <= 32'h0000_0000;
        run_q <= 1'b0;
        low_speed_q <= 1'b0;
        alarm_reset_q <= 1'b0;
        status_valid_q <= 1'b0;
    end
    else if (ce)
    begin
        if (wr_ctrl)
            ctrl_q <= {31'h0000_0000, w_data_q[`PRC_CTRL_SEMI]};
        if (wr_mask)
            irq_mask_q <= w_data_q[`PRC_IRQ_W-1:0];
        if (wr_rated & w_strb_q[0])
            rated_q[7:0] <= w_data_q[7:0];
        if (wr_rated & w_strb_q[1])
            rated_q[15:8] <= w_data_q[15:8];
        reset_cl_q <= reset_cl;
        panel_cl_q <= panel_cl;
        // a long press toggles once; a short one acts as a reset push
        if (!panel_cl)
        begin
            hold_cnt_q <= 32'h0000_0000;
            hold_done_q <= 1'b0;
        end
        else if (hold_hit)
        begin
            hold_done_q <= 1'b1;
            remote_q <= ~remote_q;
        end
        else if (!hold_done_q)
            hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
        // cause present keeps the alarm; reset alone cannot clear it
        if (alarm_cause)
            alarm_q <= 1'b1;
        else if (any_reset)
            alarm_q <= 1'b0;
        warn_q <= warn_cause;
        alarm_reset_q <= any_reset;
        run_q <= run_d & ~alarm_q;
        low_speed_q <= remote_q & lowspd_cl;
        if (valid_rise)
            status_valid_q <= 1'b1;
        else if (!status_valid_q)
            valid_cnt_q <= valid_cnt_q + 32'h0000_0001;
    end
end

////////////////////////////////////////////////////////////////////////////////
// status contacts

// products held in 19 bits so a full-scale rated speed cannot wrap
wire [18:0] spd_scaled = {3'b000, speed} * 19'd`PRC_SPD_DEN;
wire [18:0] rated_scaled = {3'b000, rated_q} * 19'd`PRC_SPD_NUM;
wire at_speed = (rated_q != 16'h0000) & (spd_scaled > rated_scaled);

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        rot_make_q <= 1'b0;
        atspd_make_q <= 1'b0;
        accel_make_q <= 1'b0;
        decel_make_q <= 1'b0;
        remote_make_q <= 1'b0;
        alarm_make_q <= 1'b0;
        alarm_break_q <= 1'b1;
        warn_make_q <= 1'b0;
        warn_break_q <= 1'b1;
    end
    else if (ce)
    begin
        rot_make_q <= rotor_turning;
        atspd_make_q <= at_speed;
        accel_make_q <= accelerating;
        decel_make_q <= decelerating;
        remote_make_q <= remote_q;
        alarm_make_q <= alarm_q;
        alarm_break_q <= ~alarm_q;
        warn_make_q <= warn_q;
        warn_break_q <= ~warn_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupts

wire [`PRC_IRQ_W-1:0] irq_evt = {hold_hit, valid_rise, any_reset, warn_rise, alarm_set};

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        irq_stat_q <= {`PRC_IRQ_W{1'b0}};
        irq_q <= 1'b0;
    end
    else if (ce)
    begin
        // a new event in the clear cycle survives
        irq_stat_q <= (irq_stat_q & ~(wr_clr ? w_data_q[`PRC_IRQ_W-1:0] :
                      {`PRC_IRQ_W{1'b0}})) | irq_evt;
        irq_q <= |(irq_stat_q & irq_mask_q);
    end
end

////////////////////////////////////////////////////////////////////////////////
// serial framer: start, 8 data lsb first, stop, no parity

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        tx_sh_q <= 10'h3FF;
        tx_bits_q <= 4'h0;
        baud_cnt_q <= 32'h0000_0000;
        ser_tx_q <= 1'b1;
    end
    else if (ce)
    begin
        // writes while a character is in flight are dropped
        if (wr_tx & ~tx_busy)
        begin
            tx_sh_q <= {1'b1, w_data_q[`PRC_DATA_BITS-1:0], 1'b0};
            tx_bits_q <= 4'd`PRC_FRAME_BITS;
            baud_cnt_q <= 32'h0000_0000;
            ser_tx_q <= 1'b0;
        end
        else if (tx_busy)
        begin
            if (baud_cnt_q >= BAUD_CYC - 1)
            begin
                baud_cnt_q <= 32'h0000_0000;
                tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                tx_bits_q <= tx_bits_q - 4'h1;
                ser_tx_q <= (tx_bits_q == 4'h1) ? 1'b1 : tx_sh_q[1];
            end
            else
                baud_cnt_q <= baud_cnt_q + 32'h0000_0001;
        end
    end
end

endmodule
`default_nettype wire

// >>> verif/prc_host_model.sv
// Purpose: host equipment switches and serial receiver
// Assumes: close_req bits are start, stop, reset, low speed, panel
// Notes: bounce is shorter than the debounce window
`timescale 1ns/1ps
`default_nettype none
module prc_host_model #(
    parameter integer BAUD_CYC = 8
) (
    // clock and wanted contacts, 1 = closed
    input wire logic aclk,
    input wire logic [4:0] close_req,
    input wire logic bounce,
    output logic [4:0] pin_n,
    // serial line from the device
    input wire logic ser_tx,
    output logic [7:0] rx_byte,
    output logic rx_stop,
    output logic rx_done
);
    logic [4:0] last_q;
    logic [4:0] chg_q;
    int bcnt;
    int rcnt;
    int rbit;
    // a changed contact chatters before it settles
    always @(posedge aclk)
    begin
        last_q <= close_req;
        if (close_req != last_q)
        begin
            chg_q <= close_req ^ last_q;
            bcnt <= bounce ? 3 : 0;
            pin_n <= pin_n ^ (close_req ^ last_q);
        end
        else if (bcnt > 0)
        begin
            bcnt <= bcnt - 1;
            pin_n <= pin_n ^ chg_q;
        end
        else
            pin_n <= ~close_req;
    end
    // samples mid-bit: start, 8 data lsb first, stop
    always @(posedge aclk)
    begin
        rx_done <= 1'b0;
        if (rbit == 0 && ser_tx === 1'b0)
        begin
            rbit <= 1;
            rcnt <= BAUD_CYC + BAUD_CYC / 2;
        end
        else if (rbit != 0 && rcnt > 1)
            rcnt <= rcnt - 1;
        else if (rbit != 0)
        begin
            rcnt <= BAUD_CYC;
            if (rbit < 9)
                rx_byte <= {ser_tx, rx_byte[7:1]};
            else
                {rx_stop, rx_done} <= {ser_tx, 1'b1};
            rbit <= (rbit < 9) ? rbit + 1 : 0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/prc_io_properties.sv
// Purpose: port-level timing checks of the remote contact block
// Assumes: bench runs the serial bit time at 8 cycles
// Notes: bound into prc_io at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module prc_io_properties #(
    parameter integer VALID_CYC = 50
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // pump state and commands
    input wire logic rotor_turning,
    input wire logic accelerating,
    input wire logic decelerating,
    input wire logic run_q,
    input wire logic alarm_reset_q,
    // contacts and serial
    input wire logic rot_make_q,
    input wire logic accel_make_q,
    input wire logic decel_make_q,
    input wire logic alarm_make_q,
    input wire logic alarm_break_q,
    input wire logic warn_make_q,
    input wire logic warn_break_q,
    input wire logic status_valid_q,
    input wire logic ser_tx_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [31:0] up_q;
    // saturates just past the valid point so the window below stays two-sided
    always @(posedge aclk)
    begin
        if (!aresetn)
            up_q <= 32'h0000_0000;
        else if (ce && up_q < VALID_CYC + 2)
            up_q <= up_q + 32'h0000_0001;
    end
    property p_alarm_pair; alarm_break_q == !alarm_make_q; endproperty
    a_alarm_pair: assert property (p_alarm_pair) else $error("alarm contacts not paired");
    property p_warn_pair; warn_break_q == !warn_make_q; endproperty
    a_warn_pair: assert property (p_warn_pair) else $error("warning contacts not paired");
    property p_alarm_stop; alarm_make_q [*2] |-> !run_q; endproperty
    a_alarm_stop: assert property (p_alarm_stop) else $error("run during alarm");
    property p_rot; $past(aresetn) && $past(ce) |-> rot_make_q == $past(rotor_turning); endproperty
    a_rot: assert property (p_rot) else $error("rotation contact wrong");
    property p_accel; $past(aresetn) && $past(ce) |-> accel_make_q == $past(accelerating); endproperty
    a_accel: assert property (p_accel) else $error("accel contact wrong");
    property p_decel; $past(aresetn) && $past(ce) |-> decel_make_q == $past(decelerating); endproperty
    a_decel: assert property (p_decel) else $error("decel contact wrong");
    property p_valid;
        (status_valid_q |-> up_q + 1 >= VALID_CYC) and (up_q >= VALID_CYC + 2 |-> status_valid_q);
    endproperty
    a_valid: assert property (p_valid) else $error("status valid at wrong time");
    property p_rst_pulse; alarm_reset_q |=> !alarm_reset_q; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
    property p_bit_len; $changed(ser_tx_q) |=> $stable(ser_tx_q) [*7]; endproperty
    a_bit_len: assert property (p_bit_len) else $error("serial bit too short");
    c_pulse: cover property (alarm_reset_q);
    c_frame: cover property ($fell(ser_tx_q));
    c_valid: cover property ($rose(status_valid_q));
endmodule
bind prc_io prc_io_properties #(.VALID_CYC(VALID_CYC)) prc_io_properties_inst (.*);
`default_nettype wire

// >>> verif/tb_prc_io.sv
// Purpose: self-checking bench of the remote contact block
// Assumes: short counts set through parameters
// Notes: host switches and serial receiver sit in the partner model
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.vh"
module tb_prc_io;
    localparam integer VC = 50;
    localparam integer HC = 20;
    localparam integer SETTLE = 20;
    logic aclk, aresetn, ce, bounce, rx_stop, rx_done;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_byte;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic rotor_turning, accelerating, decelerating, alarm_cause, warn_cause, local_run;
    logic [15:0] speed;
    logic run_q, low_speed_q, alarm_reset_q, rot_make_q, atspd_make_q, accel_make_q;
    logic decel_make_q, remote_make_q, alarm_make_q, alarm_break_q, warn_make_q, warn_break_q;
    logic status_valid_q, ser_tx_q, irq_q;
    logic [4:0] close_req, pin_n;
    int error_cnt, num_checks, cyc, pulse_cnt, base, n;
    prc_io #(.VALID_CYC(VC), .DEB_CYC(4), .HOLD_CYC(HC), .BAUD_CYC(8)) prc_io_inst (.*,
        .start_in_n(pin_n[0]), .stop_in_n(pin_n[1]), .reset_in_n(pin_n[2]),
        .lowspd_in_n(pin_n[3]), .panel_reset_n(pin_n[4]));
    prc_host_model #(.BAUD_CYC(8)) prc_host_model_inst (.aclk, .close_req, .bounce, .pin_n,
        .ser_tx(ser_tx_q), .rx_byte, .rx_stop, .rx_done);
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (alarm_reset_q === 1'b1)
            pulse_cnt <= pulse_cnt + 1;
        if (cyc == 6000)
        begin
            chk("timeout", 1, 0);
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge aclk);
    endtask
    task automatic pins(input logic [4:0] c);
        @(posedge aclk);
        close_req <= c;
        wt(SETTLE);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                {done, r} = {1'b1, s_axi_bresp};
                s_axi_bready <= 1'b0;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        while (!done)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                {done, d, r} = {1'b1, s_axi_rdata, s_axi_rresp};
                s_axi_rready <= 1'b0;
            end
        end
    endtask
    initial
    begin
        {aresetn, ce, bounce, close_req, speed, cyc, pulse_cnt, error_cnt, num_checks} = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0_0000_0000_000f;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {rotor_turning, accelerating, decelerating, alarm_cause, warn_cause, local_run} = 6'h00;
        {ce, bounce} = 2'h3;
        wt(4);
        aresetn <= 1'b1;
        wt(2);
        chk("alarm_break", alarm_break_q, 1);
        chk("warn_break", warn_break_q, 1);
        wt(VC - 8);
        chk("valid_early", status_valid_q, 0);
        wt(12);
        chk("valid_late", status_valid_q, 1);
        axi_rd(`PRC_OFS_CTRL, rd, rs);
        chk("ctrl_reset", rd, `PRC_CTRL_RST);
        axi_rd(8'h1c, rd, rs);
        chk("rd_unmapped", {rd, rs}, {32'h0000_0000, `PRC_RESP_SLVERR});
        axi_wr(8'h20, 32'h0000_0001, rs);
        chk("wr_unmapped", rs, `PRC_RESP_SLVERR);
        chk("irq_masked", irq_q, 0);
        axi_wr(`PRC_OFS_IRQ_MASK, 32'h0000_0001 << `PRC_IRQ_VALID, rs);
        wt(3);
        chk("irq_on", irq_q, 1);
        axi_wr(`PRC_OFS_IRQ_STAT, 32'h0000_0001 << `PRC_IRQ_VALID, rs);
        wt(3);
        chk("irq_cleared", irq_q, 0);
        @(posedge aclk);
        {rotor_turning, accelerating, warn_cause} <= 3'h7;
        wt(3);
        chk("contacts_a", {rot_make_q, accel_make_q, warn_make_q, warn_break_q}, 4'he);
        @(posedge aclk);
        {accelerating, decelerating, warn_cause} <= 3'h2;
        wt(3);
        chk("contacts_b", {accel_make_q, decel_make_q}, 2'h1);
        pins(5'h02);
        chk("run_idle", run_q, 0);
        pins(5'h03);
        pins(5'h02);
        chk("run_start", run_q, 1);
        pins(5'h00);
        chk("run_stop", run_q, 0);
        pins(5'h01);
        chk("stop_wins", run_q, 0);
        pins(5'h03);
        chk("alt_run", {run_q, remote_make_q}, 2'h3);
        pins(5'h0b);
        axi_rd(`PRC_OFS_STATUS, rd, rs);
        chk("lowspd", {low_speed_q, rd[`PRC_ST_LOWSPD], rd[`PRC_ST_RUN]}, 3'h7);
        pins(5'h01);
        chk("alt_stop", {run_q, low_speed_q}, 2'h0);
        pins(5'h03);
        @(posedge aclk);
        alarm_cause <= 1'b1;
        wt(4);
        chk("alarm_set", {alarm_make_q, alarm_break_q, run_q}, 3'h4);
        axi_rd(`PRC_OFS_IRQ_STAT, rd, rs);
        chk("irq_alarm", rd[`PRC_IRQ_ALARM], 1);
        alarm_cause <= 1'b0;
        wt(6);
        chk("alarm_held", alarm_make_q, 1);
        base = pulse_cnt;
        pins(5'h07);
        chk("one_reset", pulse_cnt, base + 1);
        chk("alarm_clear", alarm_make_q, 0);
        wt(10);
        chk("reset_held", pulse_cnt, base + 1);
        pins(5'h03);
        pins(5'h07);
        chk("second_reset", pulse_cnt, base + 2);
        axi_wr(`PRC_OFS_RATED, 32'h0000_03e8, rs);
        speed <= 16'h0320;
        wt(3);
        chk("atspd_edge", atspd_make_q, 0);
        speed <= 16'h0321;
        wt(3);
        chk("atspd_above", atspd_make_q, 1);
        axi_wr(`PRC_OFS_TXDATA, 32'h0000_00a5, rs);
        axi_rd(`PRC_OFS_STATUS, rd, rs);
        chk("tx_busy", rd[`PRC_ST_TXBUSY], 1);
        for (n = 0; n < 200 && rx_done !== 1'b1; n++)
            @(posedge aclk);
        chk("rx_char", {rx_byte, rx_stop}, 9'h14b);
        pins(5'h00);
        axi_wr(`PRC_OFS_CTRL, 32'h0000_0001, rs);
        axi_rd(`PRC_OFS_CTRL, rd, rs);
        chk("semi_set", rd[`PRC_CTRL_SEMI], 1);
        pins(5'h03);
        pins(5'h02);
        chk("semi_needs_start", run_q, 0);
        axi_wr(`PRC_OFS_CTRL, 32'h0000_0000, rs);
        base = pulse_cnt;
        for (n = 0; n < 2; n++)
        begin
            @(posedge aclk);
            close_req <= 5'h10;
            wt(HC + SETTLE);
            pins(5'h00);
            local_run <= 1'b1;
            wt(3);
            chk("mode", {remote_make_q, run_q}, n ? 2'h2 : 2'h1);
        end
        chk("hold_no_reset", pulse_cnt, base);
        end_sim();
    end
endmodule
`default_nettype wire
